// *** hdl/sec_pkg.sv ***
// Constants, encodings and carrier types of the serial EEPROM command port
package sec_pkg;

   // ==========================================================================
   // Timing
   // ==========================================================================
   localparam int CLK_PERIOD_NS  = 10;
   localparam int T_WC_NS        = 6_000_000;
   localparam int T_WL_NS        = 15_000_000;
   localparam int PROG_CYC       = T_WC_NS / CLK_PERIOD_NS;
   localparam int WRITE_ALL_CMD_CYC       = T_WL_NS / CLK_PERIOD_NS;
   localparam int TMR_W          = 24;

   // ==========================================================================
   // Geometry and frame layout
   // ==========================================================================
   localparam int ADDR_W         = 9;
   localparam int BYTE_W         = 8;
   localparam int WORD_W         = 16;
   localparam int MEM_DEPTH      = 512;
   localparam int FIFO_DEPTH     = 32;
   localparam int SR_W           = 26;
   localparam int CNT_W          = 5;
   localparam int HDR_BITS_BYTE  = 11;
   localparam int HDR_BITS_WORD  = 10;
   localparam int DATA_BITS_BYTE = 8;
   localparam int DATA_BITS_WORD = 16;
   localparam int OP_LSB_BYTE    = 9;
   localparam int OP_LSB_WORD    = 8;
   localparam int EXT_LSB_BYTE   = 7;
   localparam int EXT_LSB_WORD   = 6;
   localparam int OUT_LAST_BIT   = 7;

   // ==========================================================================
   // Encodings
   // ==========================================================================
   localparam logic [1:0] OP_EXT        = 2'h0;
   localparam logic [1:0] OP_WRITE      = 2'h1;
   localparam logic [1:0] OP_READ       = 2'h2;
   localparam logic [1:0] OP_ERASE      = 2'h3;
   localparam logic [1:0] EXT_DISABLE   = 2'h0;
   localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
   localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
   localparam logic [1:0] EXT_ENABLE    = 2'h3;
   localparam logic [7:0] ERASED_BYTE   = 8'hFF;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_HDR   = 3'b001,
      ST_DATA  = 3'b011,
      ST_READ  = 3'b010,
      ST_DONE  = 3'b110,
      ST_ARMED = 3'b111
   } sec_state_t;

   typedef enum logic [2:0] {
      PK_NONE      = 3'h0,
      PK_ERASE     = 3'h1,
      PK_ERASE_ALL = 3'h2,
      PK_WRITE     = 3'h3,
      PK_WRITE_ALL = 3'h4
   } sec_prog_kind_t;

   // ==========================================================================
   // Carriers
   // ==========================================================================
   typedef struct packed {
      logic org_word;
      logic serial_in;
      logic sclk;
      logic cs;
   } sec_pins_t;

   typedef struct packed {
      sec_prog_kind_t          kind;
      logic                    org_word;
      logic [ADDR_W-1:0]       addr;
      logic [WORD_W-1:0]       data;
   } sec_prog_req_t;

endpackage

// *** hdl/sec_mem.sv ***
// Byte array with one write port and one registered read port
`timescale 1ns/100ps
module sec_mem #(
   parameter int W     = 8,
   parameter int DEPTH = 512
) (
   input  wire logic                     i_clk,
   input  wire logic                     i_rstn,
   input  wire logic                     i_we,
   input  wire logic [$clog2(DEPTH)-1:0] i_waddr,
   input  wire logic [W-1:0]             i_wdata,
   input  wire logic                     i_re,
   input  wire logic [$clog2(DEPTH)-1:0] i_raddr,
   output logic      [W-1:0]             o_rdata
);

   // ==========================================================================
   // Storage
   // ==========================================================================
   logic [W-1:0] mem [DEPTH];

   // No reset on the array: contents are nonvolatile by intent
   always_ff @(posedge i_clk)
   begin
      if (i_we)
      begin
         mem[i_waddr] <= i_wdata;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_rdata <= '0;
      end
      else if (i_re)
      begin
         o_rdata <= mem[i_raddr];
      end
   end

endmodule // sec_mem

// *** hdl/sec_fifo.sv ***
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module sec_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 32
) (
   input  wire logic         i_clk,
   input  wire logic         i_rstn,
   input  wire logic         i_flush,
   input  wire logic         i_in_valid,
   output logic              o_in_ready,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_out_valid,
   input  wire logic         i_out_ready,
   output logic      [W-1:0] o_out_data
);

   localparam int AW = $clog2(DEPTH);

   // ==========================================================================
   // Pointers and count
   // ==========================================================================
   logic [W-1:0]  buf_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          pop;

   assign o_in_ready  = cnt_q != (AW+1)'(DEPTH);
   assign o_out_valid = cnt_q != '0;
   assign o_out_data  = buf_q[rd_ptr_q];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = i_out_ready & o_out_valid;

   always_ff @(posedge i_clk)
   begin
      if (push)
      begin
         buf_q[wr_ptr_q] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q    <= '0;
      end
      else if (i_flush)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q    <= '0;
      end
      else
      begin
         wr_ptr_q <= push ? wr_ptr_q + 1'b1 : wr_ptr_q;
         rd_ptr_q <= pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
         cnt_q    <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule // sec_fifo

// *** hdl/sec_command_port.sv ***
// Command front end of a three-wire serial EEPROM
`timescale 1ns/100ps

// Functional notes
// - Chip select low deselects; programming finishes first
// - Programming cycle runs to end regardless
// - Chip select low holds decoder in reset
// - Sample and shift on rising serial clock
// - Paused serial clock keeps shift state intact
// - Idle clocks without start change nothing
// - Start bit: first rise with select, input high
// - Execute only after full bit count
// - Ignore clock and input after last bit
// - Byte mode: 9 address, 8 data bits
// - Word mode: 8 address, 16 data bits
// - Output floats unless data or status shown
// - Raised select shows busy low, ready high
// - Select low whole cycle: float, later ready
// - Power-up disabled; erase and write refused
// - Erase sets location to ones on fall
// - Erase-all sets array to ones on fall
// - Held select continues reading next locations
// - Write erases then programs the location
// - Write-all includes erase-all, needs enable
// - Enable persists until disable; reads ungated
module sec_command_port #(
   parameter int PROG_CYCLES  = sec_pkg::PROG_CYC,
   parameter int WRALL_CYCLES = sec_pkg::WRITE_ALL_CMD_CYC
) (
   input  wire logic i_clk,
   input  wire logic i_rstn,
   input  wire logic i_cs,
   input  wire logic i_sclk,
   input  wire logic i_serial_in,
   input  wire logic i_org_word,
   output logic      o_serial_out,
   output logic      o_serial_out_oe,
   output logic      o_ready_busy_flag
);

   localparam int NPIN = 4;

   // ==========================================================================
   // Pin synchronisers
   // ==========================================================================
   logic [NPIN-1:0]   pin_raw;
   logic [NPIN-1:0]   sync1_q;
   logic [NPIN-1:0]   sync2_q;
   sec_pkg::sec_pins_t pin_s;
   sec_pkg::sec_pins_t pin_p_q;

   assign pin_raw = {i_org_word, i_serial_in, i_sclk, i_cs};

   generate
      for (genvar g = 0; g < NPIN; g++)
      begin : g_sync
         always_ff @(posedge i_clk or negedge i_rstn)
         begin
            if (!i_rstn)
            begin
               sync1_q[g] <= 1'b0;
               sync2_q[g] <= 1'b0;
            end
            else
            begin
               sync1_q[g] <= pin_raw[g];
               sync2_q[g] <= sync1_q[g];
            end
         end
      end
   endgenerate

   assign pin_s = sync2_q;

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         pin_p_q <= '0;
      end
      else
      begin
         pin_p_q <= pin_s;
      end
   end

   // Edges, not levels, advance the shifter, so a stopped clock is harmless
   wire cs_s      = pin_s.cs;
   wire sclk_rise = pin_s.sclk & ~pin_p_q.sclk;
   wire cs_fall   = pin_p_q.cs & ~pin_s.cs;

   // ==========================================================================
   // Command decoder
   // ==========================================================================
   sec_pkg::sec_state_t        state_q, state_d;
   logic [sec_pkg::CNT_W-1:0]  cnt_q, cnt_d;
   logic [sec_pkg::SR_W-1:0]   sr_q, sr_d;
   logic                       org_q, org_d;
   logic                       enable_q, enable_d;
   sec_pkg::sec_prog_req_t     req_q, req_d;
   logic                       busy_q;
   logic                       sweep_q;

   wire [sec_pkg::SR_W-1:0]    sr_nx   = {sr_q[sec_pkg::SR_W-2:0], pin_s.serial_in};
   wire [sec_pkg::CNT_W-1:0]   cnt_nx  = cnt_q + 1'b1;
   wire [sec_pkg::CNT_W-1:0]   hdr_len = org_q ? sec_pkg::CNT_W'(sec_pkg::HDR_BITS_WORD)
                                               : sec_pkg::CNT_W'(sec_pkg::HDR_BITS_BYTE);
   wire [sec_pkg::CNT_W-1:0]   dat_len = org_q ? sec_pkg::CNT_W'(sec_pkg::DATA_BITS_WORD)
                                               : sec_pkg::CNT_W'(sec_pkg::DATA_BITS_BYTE);

   // Field extraction for both organisations
   wire [1:0] op_nx  = org_q ? sr_nx[sec_pkg::OP_LSB_WORD +: 2] : sr_nx[sec_pkg::OP_LSB_BYTE +: 2];
   wire [1:0] ext_nx = org_q ? sr_nx[sec_pkg::EXT_LSB_WORD +: 2] : sr_nx[sec_pkg::EXT_LSB_BYTE +: 2];
   wire [sec_pkg::ADDR_W-1:0] addr_nx = org_q ? {1'b0, sr_nx[sec_pkg::ADDR_W-2:0]}
                                              : sr_nx[sec_pkg::ADDR_W-1:0];
   wire [sec_pkg::WORD_W-1:0] wdat_nx = org_q ? sr_nx[sec_pkg::WORD_W-1:0]
                                              : {{sec_pkg::BYTE_W{1'b0}}, sr_nx[sec_pkg::BYTE_W-1:0]};

   wire start_bit = (state_q == sec_pkg::ST_IDLE) & sclk_rise & pin_s.serial_in & ~busy_q;
   wire hdr_done  = (state_q == sec_pkg::ST_HDR) & sclk_rise & (cnt_nx == hdr_len);
   wire dat_done  = (state_q == sec_pkg::ST_DATA) & sclk_rise & (cnt_nx == dat_len);
   wire is_ext    = op_nx == sec_pkg::OP_EXT;
   wire is_read   = op_nx == sec_pkg::OP_READ;
   wire is_erase  = op_nx == sec_pkg::OP_ERASE;
   wire is_write  = op_nx == sec_pkg::OP_WRITE;
   wire is_erase_all_cmd   = is_ext & (ext_nx == sec_pkg::EXT_ERASE_ALL);
   wire is_write_all_cmd   = is_ext & (ext_nx == sec_pkg::EXT_WRITE_ALL);
   wire is_en     = is_ext & (ext_nx == sec_pkg::EXT_ENABLE);
   wire is_dis    = is_ext & (ext_nx == sec_pkg::EXT_DISABLE);

   always_comb
   begin
      state_d  = state_q;
      cnt_d    = cnt_q;
      sr_d     = sr_q;
      org_d    = org_q;
      enable_d = enable_q;
      req_d    = req_q;
      if (hdr_done && is_en)
      begin
         enable_d = 1'b1;
      end
      else if (hdr_done && is_dis)
      begin
         enable_d = 1'b0;
      end
      if (!cs_s)
      begin
         state_d = sec_pkg::ST_IDLE;
         cnt_d   = '0;
      end
      else if (sclk_rise)
      begin
         case (state_q)
            sec_pkg::ST_IDLE:
            begin
               if (start_bit)
               begin
                  state_d = sec_pkg::ST_HDR;
                  cnt_d   = '0;
                  org_d   = pin_s.org_word;
               end
            end
            sec_pkg::ST_HDR:
            begin
               sr_d  = sr_nx;
               cnt_d = cnt_nx;
               if (hdr_done)
               begin
                  cnt_d          = '0;
                  req_d.org_word = org_q;
                  req_d.addr     = addr_nx;
                  req_d.kind     = is_erase ? sec_pkg::PK_ERASE :
                                   is_erase_all_cmd  ? sec_pkg::PK_ERASE_ALL :
                                   is_write ? sec_pkg::PK_WRITE :
                                   is_write_all_cmd  ? sec_pkg::PK_WRITE_ALL : sec_pkg::PK_NONE;
                  if (is_read)
                  begin
                     state_d = sec_pkg::ST_READ;
                  end
                  else if (is_write || is_write_all_cmd)
                  begin
                     state_d = sec_pkg::ST_DATA;
                  end
                  else if (is_erase || is_erase_all_cmd)
                  begin
                     state_d = enable_q ? sec_pkg::ST_ARMED : sec_pkg::ST_DONE;
                  end
                  else
                  begin
                     state_d = sec_pkg::ST_DONE;
                  end
               end
            end
            sec_pkg::ST_DATA:
            begin
               sr_d  = sr_nx;
               cnt_d = cnt_nx;
               if (dat_done)
               begin
                  req_d.data = wdat_nx;
                  state_d    = enable_q ? sec_pkg::ST_ARMED : sec_pkg::ST_DONE;
               end
            end
            default:
            begin
               state_d = state_q;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         state_q  <= sec_pkg::ST_IDLE;
         cnt_q    <= '0;
         sr_q     <= '0;
         org_q    <= 1'b0;
         enable_q <= 1'b0;
         req_q    <= '0;
      end
      else
      begin
         state_q  <= state_d;
         cnt_q    <= cnt_d;
         sr_q     <= sr_d;
         org_q    <= org_d;
         enable_q <= enable_d;
         req_q    <= req_d;
      end
   end

   // ==========================================================================
   // Read prefetch and serial output shifter
   // ==========================================================================
   logic [sec_pkg::ADDR_W-1:0] pf_addr_q;
   logic                       inflight_q;
   logic [sec_pkg::BYTE_W-1:0] mem_rdata;
   logic                       fifo_in_ready;
   logic                       fifo_out_valid;
   logic [sec_pkg::BYTE_W-1:0] fifo_out_data;
   logic [sec_pkg::BYTE_W-1:0] out_sh_q;
   logic [2:0]                 out_left_q;
   logic                       so_bit_q;

   // One read in flight at a time keeps the FIFO from ever overflowing
   wire in_read  = state_q == sec_pkg::ST_READ;
   wire rd_issue = in_read & fifo_in_ready & ~inflight_q;
   wire out_pop  = in_read & sclk_rise & (out_left_q == '0) & fifo_out_valid;
   wire [sec_pkg::ADDR_W-1:0] rd_start = org_q ? {addr_nx[sec_pkg::ADDR_W-2:0], 1'b0} : addr_nx;

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         pf_addr_q  <= '0;
         inflight_q <= 1'b0;
      end
      else
      begin
         pf_addr_q  <= (hdr_done && is_read) ? rd_start : pf_addr_q + sec_pkg::ADDR_W'(rd_issue);
         inflight_q <= rd_issue;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         so_bit_q   <= 1'b0;
         out_sh_q   <= '0;
         out_left_q <= '0;
      end
      else if (hdr_done && is_read)
      begin
         so_bit_q   <= 1'b0;
         out_left_q <= '0;
      end
      else if (out_pop)
      begin
         so_bit_q   <= fifo_out_data[sec_pkg::OUT_LAST_BIT];
         out_sh_q   <= {fifo_out_data[sec_pkg::OUT_LAST_BIT-1:0], 1'b0};
         out_left_q <= 3'(sec_pkg::OUT_LAST_BIT);
      end
      else if (in_read && sclk_rise && out_left_q != '0)
      begin
         so_bit_q   <= out_sh_q[sec_pkg::OUT_LAST_BIT];
         out_sh_q   <= {out_sh_q[sec_pkg::OUT_LAST_BIT-1:0], 1'b0};
         out_left_q <= out_left_q - 1'b1;
      end
   end

   sec_fifo #(
      .W     (sec_pkg::BYTE_W),
      .DEPTH (sec_pkg::FIFO_DEPTH)
   ) u_fifo (
      .i_clk       (i_clk),
      .i_rstn      (i_rstn),
      .i_flush     (~in_read),
      .i_in_valid  (inflight_q & in_read),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (mem_rdata),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (out_pop),
      .o_out_data  (fifo_out_data)
   );

   // ==========================================================================
   // Self-timed programming engine
   // ==========================================================================
   logic [sec_pkg::TMR_W-1:0]  tmr_q;
   logic [sec_pkg::ADDR_W-1:0] idx_q;
   logic                       pass_q;
   logic                       status_q;

   // Started by the select fall; chip select plays no further part
   wire prog_start = cs_fall & (state_q == sec_pkg::ST_ARMED) & ~busy_q;
   wire all_kind   = (req_q.kind == sec_pkg::PK_ERASE_ALL) | (req_q.kind == sec_pkg::PK_WRITE_ALL);
   wire prog_kind  = (req_q.kind == sec_pkg::PK_WRITE) | (req_q.kind == sec_pkg::PK_WRITE_ALL);
   wire [sec_pkg::ADDR_W-1:0] last_idx = all_kind ? sec_pkg::ADDR_W'(sec_pkg::MEM_DEPTH - 1)
                                                  : sec_pkg::ADDR_W'(req_q.org_word);
   wire sweep_last = idx_q == last_idx;
   wire [sec_pkg::ADDR_W-1:0] one_addr = req_q.org_word ? {req_q.addr[sec_pkg::ADDR_W-2:0], idx_q[0]} : req_q.addr;
   wire [sec_pkg::ADDR_W-1:0] wr_addr  = all_kind ? idx_q : one_addr;
   wire [sec_pkg::BYTE_W-1:0] prog_byte = (req_q.org_word && !idx_q[0]) ? req_q.data[sec_pkg::WORD_W-1:sec_pkg::BYTE_W]
                                                                        : req_q.data[sec_pkg::BYTE_W-1:0];
   // Pass zero always erases; writes follow with a programming pass
   wire [sec_pkg::BYTE_W-1:0] wr_data  = pass_q ? prog_byte : sec_pkg::ERASED_BYTE;
   wire [sec_pkg::TMR_W-1:0]  tmr_load = (req_q.kind == sec_pkg::PK_WRITE_ALL) ? sec_pkg::TMR_W'(WRALL_CYCLES)
                                                                               : sec_pkg::TMR_W'(PROG_CYCLES);
   wire busy_d = prog_start | (busy_q & ((tmr_q != '0) | sweep_q));

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         busy_q  <= 1'b0;
         sweep_q <= 1'b0;
         tmr_q   <= '0;
         idx_q   <= '0;
         pass_q  <= 1'b0;
      end
      else if (prog_start)
      begin
         busy_q  <= 1'b1;
         sweep_q <= 1'b1;
         tmr_q   <= tmr_load;
         idx_q   <= '0;
         pass_q  <= 1'b0;
      end
      else
      begin
         busy_q <= busy_d;
         tmr_q  <= (tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
         if (sweep_q && sweep_last)
         begin
            sweep_q <= ~pass_q & prog_kind;
            pass_q  <= 1'b1;
            idx_q   <= '0;
         end
         else if (sweep_q)
         begin
            idx_q <= idx_q + 1'b1;
         end
      end
   end

   sec_mem #(
      .W     (sec_pkg::BYTE_W),
      .DEPTH (sec_pkg::MEM_DEPTH)
   ) u_mem (
      .i_clk   (i_clk),
      .i_rstn  (i_rstn),
      .i_we    (sweep_q),
      .i_waddr (wr_addr),
      .i_wdata (wr_data),
      .i_re    (rd_issue),
      .i_raddr (pf_addr_q),
      .o_rdata (mem_rdata)
   );

   // ==========================================================================
   // Serial output drive
   // ==========================================================================
   // Status stays visible until the next start bit, so a late poll reads ready
   wire status_d = prog_start | (status_q & ~start_bit);
   wire show_st  = status_q & (state_q == sec_pkg::ST_IDLE);
   wire oe_d     = cs_s & (in_read | show_st);
   wire so_d     = in_read ? so_bit_q : ~busy_q;

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         status_q          <= 1'b0;
         o_serial_out      <= 1'b0;
         o_serial_out_oe   <= 1'b0;
         o_ready_busy_flag <= 1'b1;
      end
      else
      begin
         status_q          <= status_d;
         o_serial_out      <= oe_d & so_d;
         o_serial_out_oe   <= oe_d;
         o_ready_busy_flag <= ~busy_d;
      end
   end

endmodule // sec_command_port

// *** dv/sec_command_port_properties.sv ***
// Port-level properties of the command port
`timescale 1ns/100ps
module sec_command_port_properties #(
   parameter int PROG_CYCLES  = sec_pkg::PROG_CYC,
   parameter int WRALL_CYCLES = sec_pkg::WRITE_ALL_CMD_CYC
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_cs,
   input wire logic o_serial_out,
   input wire logic o_serial_out_oe,
   input wire logic o_ready_busy_flag
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   // ====
   // Busy length; sweeps hide under the cycle count
   int busy_q;
   always_ff @(posedge i_clk or negedge i_rstn)
      if (!i_rstn) busy_q <= 0;
      else busy_q <= o_ready_busy_flag ? 0 : busy_q + 1;
   sequence s_cs_drop; $fell(i_cs); endsequence
   sequence s_busy_go; $fell(o_ready_busy_flag); endsequence
   property p_oe_release; s_cs_drop |-> ##[1:6] !o_serial_out_oe; endproperty
   property p_busy_cs; s_busy_go |-> !i_cs; endproperty
   property p_busy_min; $rose(o_ready_busy_flag) |-> busy_q >= PROG_CYCLES; endproperty
   property p_busy_max; busy_q <= WRALL_CYCLES + 1100; endproperty
   property p_status; (o_serial_out_oe && !o_ready_busy_flag) [*2] |-> !o_serial_out; endproperty
   property p_quiet; !i_cs [*6] |-> !o_serial_out_oe; endproperty
   property p_float_zero; !o_serial_out_oe |-> !o_serial_out; endproperty
   property p_power_up; $rose(i_rstn) |-> o_ready_busy_flag && !o_serial_out_oe; endproperty
   a_oe_release: assert property (p_oe_release) else $error("oe kept after select fell");
   a_busy_cs: assert property (p_busy_cs) else $error("busy began with select high");
   a_busy_min: assert property (p_busy_min) else $error("busy too short");
   a_busy_max: assert property (p_busy_max) else $error("busy too long");
   a_status: assert property (p_status) else $error("status high while busy");
   a_quiet: assert property (p_quiet) else $error("output driven while deselected");
   a_float_zero: assert property (p_float_zero) else $error("data while floating");
   a_power_up: assert property (p_power_up) else $error("bad state after reset");
endmodule // sec_command_port_properties

// *** dv/sec_host_model.sv ***
// Host controller model for the three-wire serial bus
`timescale 1ns/100ps
module sec_host_model (
   input  wire logic i_clk,
   input  wire logic i_so,
   input  wire logic i_so_oe,
   output logic      o_cs,
   output logic      o_sclk,
   output logic      o_serial_in
);
   wire so_line = i_so_oe ? i_so : 1'bz;
   initial
   begin
      o_cs = 1'b0;
      o_sclk = 1'b0;
      o_serial_in = 1'b0;
   end
   // ====
   // One 160 ns serial clock; q is the bit shown before this rise
   task automatic bit_cyc(input logic b, output logic q);
      o_serial_in = b;
      repeat (8) @(negedge i_clk);
      q = so_line;
      o_sclk = 1'b1;
      repeat (8) @(negedge i_clk);
      o_sclk = 1'b0;
   endtask
   // Two idle clocks lead every frame; clock stands still after it
   task automatic frame(input logic [26:0] bits, input int n, input int nrd, output logic [16:0] rd);
      logic q;
      rd = '0;
      o_cs = 1'b1;
      bit_cyc(1'b0, q);
      bit_cyc(1'b0, q);
      for (int i = n - 1; i >= 0; i--) bit_cyc(bits[i], q);
      for (int i = nrd - 1; i >= 0; i--)
      begin
         bit_cyc(~o_serial_in, q);
         rd[i] = q;
      end
      o_serial_in = ~o_serial_in;
   endtask
   task automatic cs_low;
      o_cs = 1'b0;
      repeat (30) @(negedge i_clk);
   endtask
   // Raise select, note first status bit, then wait for ready
   task automatic poll(output logic [1:0] st);
      int n;
      o_cs = 1'b1;
      n = 0;
      repeat (8) @(negedge i_clk);
      st[1] = so_line;
      while (so_line !== 1'b1 && n < 5000) @(negedge i_clk) n++;
      st[0] = so_line;
   endtask
endmodule // sec_host_model

// *** dv/sec_command_port_tb_top.sv ***
// Self-checking testbench of the command port
`timescale 1ns/100ps
module sec_command_port_tb_top;
   logic        i_clk = 1'b0;
   logic        i_rstn = 1'b0;
   logic        org = 1'b0;
   logic        cs, sclk, si, so, oe, rdy, hi;
   logic [16:0] rd;
   logic [1:0]  st;
   int          failures = 0;
   int          n_tests = 0;
   always #5 i_clk = ~i_clk;
   sec_command_port #(.PROG_CYCLES(2000), .WRALL_CYCLES(3000)) dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_cs(cs),
      .i_sclk(sclk), .i_serial_in(si), .i_org_word(org), .o_serial_out(so), .o_serial_out_oe(oe),
      .o_ready_busy_flag(rdy));
   sec_host_model host (.i_clk(i_clk), .i_so(so), .i_so_oe(oe), .o_cs(cs), .o_sclk(sclk), .o_serial_in(si));
   // ====
   task automatic chk(input string nm, input logic [16:0] exp, input logic [16:0] got);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic tally_and_finish;
      if (failures == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic prog(input string nm);
      host.cs_low();
      chk({nm, " busy"}, 17'h0, 17'(rdy));
      host.poll(st);
      chk({nm, " status"}, 17'h1, 17'(st));
      if (st[0] !== 1'b1) tally_and_finish();
      host.cs_low();
   endtask
   task automatic s_refused;
      host.frame(27'({1'b1, 2'h0, 2'h3, 3'h0}), 8, 0, rd);
      host.cs_low();
      host.frame(27'({1'b1, 2'h1, 9'h010, 8'h00}), 20, 0, rd);
      host.cs_low();
      chk("refused", 17'h1, 17'(rdy));
   endtask
   task automatic s_byte;
      host.frame(27'({1'b1, 2'h0, 2'h3, 7'h00}), 12, 0, rd);
      host.cs_low();
      host.frame(27'({1'b1, 2'h3, 9'h000}), 12, 0, rd);
      prog("erase");
      host.frame(27'({1'b1, 2'h1, 9'h1FF, 8'hA5}), 20, 0, rd);
      prog("write");
      host.frame(27'({1'b1, 2'h2, 9'h1FF}), 12, 17, rd);
      chk("seq read", 17'h0_A5FF, rd);
      host.cs_low();
   endtask
   task automatic s_word;
      org = 1'b1;
      hi = 1'b0;
      host.frame(27'({1'b1, 2'h1, 8'h05, 16'h1234}), 27, 0, rd);
      host.cs_low();
      repeat (2500) @(negedge i_clk) hi |= oe;
      chk("float", 17'h0, 17'(hi));
      host.poll(st);
      chk("late status", 17'h3, 17'(st));
      host.cs_low();
      host.frame(27'({1'b1, 2'h2, 8'h05}), 11, 17, rd);
      chk("word read", 17'h0_1234, rd);
      host.cs_low();
      org = 1'b0;
   endtask
   task automatic s_all;
      host.frame(27'({1'b1, 2'h0, 2'h1, 7'h00, 8'h3C}), 20, 0, rd);
      prog("write_all_cmd");
      host.frame(27'({1'b1, 2'h2, 9'h123}), 12, 9, rd);
      chk("write_all_cmd read", 17'h0_003C, rd);
      host.cs_low();
      host.frame(27'({1'b1, 2'h0, 2'h2, 7'h00}), 12, 0, rd);
      prog("erase_all_cmd");
      host.frame(27'({1'b1, 2'h0, 2'h0, 7'h00}), 12, 0, rd);
      host.cs_low();
      host.frame(27'({1'b1, 2'h1, 9'h123, 8'h00}), 20, 0, rd);
      host.cs_low();
      chk("disabled", 17'h1, 17'(rdy));
      host.frame(27'({1'b1, 2'h2, 9'h123}), 12, 9, rd);
      chk("erase_all_cmd read", 17'h0_00FF, rd);
      host.cs_low();
   endtask
   initial
   begin
      repeat (3) @(negedge i_clk);
      i_rstn = 1'b1;
      repeat (3) @(negedge i_clk);
      s_refused();
      s_byte();
      s_word();
      s_all();
      tally_and_finish();
   end
endmodule // sec_command_port_tb_top
bind sec_command_port sec_command_port_properties #(.PROG_CYCLES(PROG_CYCLES), .WRALL_CYCLES(WRALL_CYCLES)) u_props (
   .i_clk(i_clk), .i_rstn(i_rstn), .i_cs(i_cs), .o_serial_out(o_serial_out),
   .o_serial_out_oe(o_serial_out_oe), .o_ready_busy_flag(o_ready_busy_flag));
